/* rtl/sync_serial_master_txrx.sv */
// Purpose: synchronous half-duplex serial transceiver, master and slave
// Assumes: one system clock, link pins sampled through two flip-flops
// Notes: clearing the port enable resets the serial engine state
`timescale 1ns/100ps

module sync_serial_master_txrx #(
    parameter int DIVISOR_WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    output logic receive_ready_flag,
    output logic transmit_empty_flag
);
    typedef enum logic [1:0] {IDLE, TX, RX} phase_t;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] baud_control_bits;
    logic [7:0] receive_status_control;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] transmit_holding_data;
    logic [7:0] transmit_status_control;
    logic holding_full;
    logic holding_ninth;
    phase_t phase;
    logic [8:0] transmit_shifter;
    logic [8:0] receive_shifter;
    logic [3:0] bit_count;
    logic [DIVISOR_WIDTH-1:0] baud_count;
    logic clock_level;
    localparam int FIFO_DEPTH_L = sync_serial_pkg::FIFO_DEPTH;
    logic [8:0] fifo_mem [FIFO_DEPTH_L];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] fifo_count;
    logic [2:0] pin_clock_sync;
    logic [1:0] pin_data_sync;
    logic overrun_single;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] r);
        hit = strobe && (a == r);
    endfunction

    wire port_on = receive_status_control[sync_serial_pkg::RS_PORT_ENABLE];
    wire master = transmit_status_control[sync_serial_pkg::TS_MASTER];
    wire sync_mode = transmit_status_control[sync_serial_pkg::TS_SYNC];
    wire tx_on = transmit_status_control[sync_serial_pkg::TS_ENABLE];
    wire single_rx = receive_status_control[sync_serial_pkg::RS_SINGLE];
    wire cont_rx = receive_status_control[sync_serial_pkg::RS_CONTINUOUS];
    wire rx_ninth = receive_status_control[sync_serial_pkg::RS_NINTH_ENABLE];
    wire tx_ninth = transmit_status_control[sync_serial_pkg::TS_NINTH_ENABLE];
    wire polarity = baud_control_bits[sync_serial_pkg::BC_POLARITY];
    wire overrun = receive_status_control[sync_serial_pkg::RS_OVERRUN];
    wire active = port_on && sync_mode;
    wire rx_mode = active && (single_rx || cont_rx);
    wire wr_hold = hit(reg_write, reg_addr, sync_serial_pkg::ADDR_TRANSMIT_DATA);
    wire wr_rstat = hit(reg_write, reg_addr, sync_serial_pkg::ADDR_RECEIVE_STATUS);
    wire rd_data = hit(reg_read, reg_addr, sync_serial_pkg::ADDR_RECEIVE_DATA);
    wire [3:0] char_bits_rx = rx_ninth ? sync_serial_pkg::BITS_WIDE : sync_serial_pkg::BITS_NARROW;
    wire [3:0] char_bits_tx = tx_ninth ? sync_serial_pkg::BITS_WIDE : sync_serial_pkg::BITS_NARROW;
    wire [DIVISOR_WIDTH-1:0] divisor = DIVISOR_WIDTH'({baud_divisor_high, baud_divisor_low});
    wire tick = (baud_count == '0);
    // slave clock edges; idle level is the polarity bit
    wire pin_rise = pin_clock_sync[1] && !pin_clock_sync[2];
    wire pin_fall = !pin_clock_sync[1] && pin_clock_sync[2];
    wire lead_edge = master ? (tick && clock_level == polarity) : (polarity ? pin_fall : pin_rise);
    wire trail_edge = master ? (tick && clock_level != polarity) : (polarity ? pin_rise : pin_fall);
    wire load_tx = active && tx_on && !rx_mode && phase == IDLE && holding_full;
    wire rx_start = rx_mode && phase == IDLE && !overrun;
    wire last_tx = phase == TX && trail_edge && bit_count == char_bits_tx - 4'h1;
    wire last_rx = phase == RX && trail_edge && bit_count == char_bits_rx - 4'h1;
    wire fifo_full = fifo_count == 2'(FIFO_DEPTH_L);
    wire push = last_rx && !fifo_full;
    wire lost = last_rx && fifo_full;
    wire pop = rd_data && fifo_count != 2'h0;
    wire [8:0] top = fifo_mem[rd_ptr];
    wire abort = phase == RX && !rx_mode;

    // ------------------------------------------------------------
    // link input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        pin_clock_sync <= {pin_clock_sync[1:0], serial_clock_pin_in};
        pin_data_sync <= {pin_data_sync[0], serial_data_pin_in};
    end

    // ------------------------------------------------------------
    // register writes and self-clearing bits
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            baud_control_bits <= sync_serial_pkg::RESET_BYTE;
            receive_status_control <= sync_serial_pkg::RESET_BYTE;
            baud_divisor_low <= sync_serial_pkg::RESET_BYTE;
            baud_divisor_high <= sync_serial_pkg::RESET_BYTE;
            transmit_status_control <= sync_serial_pkg::RESET_BYTE;
            overrun_single <= 1'b0;
        end
        else
        begin
            if (hit(reg_write, reg_addr, sync_serial_pkg::ADDR_BAUD_CONTROL))
                baud_control_bits <= reg_wdata & 8'h18;
            if (hit(reg_write, reg_addr, sync_serial_pkg::ADDR_DIVISOR_LOW))
                baud_divisor_low <= reg_wdata;
            if (hit(reg_write, reg_addr, sync_serial_pkg::ADDR_DIVISOR_HIGH))
                baud_divisor_high <= reg_wdata;
            if (hit(reg_write, reg_addr, sync_serial_pkg::ADDR_TRANSMIT_STATUS))
                transmit_status_control <= reg_wdata & 8'hF5;
            if (wr_rstat)
                receive_status_control[7:4] <= reg_wdata[7:4];
            // single bit clears after one character
            if (last_rx && single_rx)
                receive_status_control[sync_serial_pkg::RS_SINGLE] <= 1'b0;
            // set wins over clear; remember the mode it came in
            if (lost)
            begin
                receive_status_control[sync_serial_pkg::RS_OVERRUN] <= 1'b1;
                overrun_single <= !cont_rx;
            end
            // single mode clears on data read, continuous on enable drop
            else if (!port_on || (overrun_single ? rd_data : !cont_rx))
                receive_status_control[sync_serial_pkg::RS_OVERRUN] <= 1'b0;
            receive_status_control[3:2] <= 2'h0;
            // ninth bit of oldest unread character
            receive_status_control[sync_serial_pkg::RS_NINTH_BIT] <= top[8];
        end
    end

    // ------------------------------------------------------------
    // transmit holding register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset || !port_on)
        begin
            transmit_holding_data <= sync_serial_pkg::RESET_BYTE;
            holding_full <= 1'b0;
            holding_ninth <= 1'b0;
        end
        else if (wr_hold)
        begin
            transmit_holding_data <= reg_wdata;
            holding_ninth <= transmit_status_control[sync_serial_pkg::TS_NINTH_BIT];
            holding_full <= 1'b1;
        end
        else if (load_tx)
            holding_full <= 1'b0;
    end

    // ------------------------------------------------------------
    // baud divider and master clock
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset || phase == IDLE || abort || !master)
        begin
            baud_count <= divisor;
            clock_level <= polarity;
        end
        else if (tick)
        begin
            baud_count <= divisor;
            clock_level <= !clock_level;
        end
        else
            baud_count <= baud_count - 1'b1;
    end

    // ------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset || !port_on || abort)
        begin
            phase <= IDLE;
            bit_count <= 4'h0;
            transmit_shifter <= 9'h000;
            receive_shifter <= 9'h000;
        end
        else
        begin
            case (phase)
                IDLE:
                begin
                    bit_count <= 4'h0;
                    if (load_tx)
                    begin
                        transmit_shifter <= {holding_ninth, transmit_holding_data};
                        phase <= TX;
                    end
                    else if (rx_start)
                        phase <= RX;
                end
                TX:
                begin
                    // shift on trailing edge, new bit at next leading edge
                    if (trail_edge)
                    begin
                        transmit_shifter <= {1'b0, transmit_shifter[8:1]};
                        bit_count <= bit_count + 4'h1;
                    end
                    if (last_tx)
                        phase <= IDLE;
                end
                RX:
                begin
                    if (trail_edge)
                    begin
                        receive_shifter <= {pin_data_sync[1], receive_shifter[8:1]};
                        bit_count <= bit_count + 4'h1;
                    end
                    if (last_rx)
                        phase <= IDLE;
                end
                default:
                    phase <= IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // two-deep receive FIFO
    // ------------------------------------------------------------
    wire [8:0] rx_char = rx_ninth ? {pin_data_sync[1], receive_shifter[8:1]}
                                  : {1'b0, pin_data_sync[1], receive_shifter[8:2]};
    always_ff @(posedge sys_clk)
    begin
        if (reset || !port_on)
        begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            fifo_count <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                fifo_mem[wr_ptr] <= rx_char;
                wr_ptr <= !wr_ptr;
            end
            if (pop)
                rd_ptr <= !rd_ptr;
            fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // ------------------------------------------------------------
    // pins, flags and read data
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= 1'b0;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            receive_ready_flag <= 1'b0;
            transmit_empty_flag <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            // data driver on only for transmit
            serial_data_pin_oe <= active && !rx_mode && tx_on;
            // next bit appears together with the leading clock edge
            if (phase == TX && lead_edge)
                serial_data_pin_out <= transmit_shifter[0];
            serial_clock_pin_oe <= active && master;
            // idle level follows polarity; pin shows the next level
            serial_clock_pin_out <= (phase == IDLE || abort || !master) ? polarity
                                                                        : clock_level ^ tick;
            receive_ready_flag <= (fifo_count + {1'b0, push} - {1'b0, pop}) != 2'h0;
            transmit_empty_flag <= port_on && !holding_full && !wr_hold;
            case (reg_addr)
                sync_serial_pkg::ADDR_BAUD_CONTROL:
                    reg_rdata <= baud_control_bits | {1'b0, phase != RX, 6'h00};
                sync_serial_pkg::ADDR_RECEIVE_STATUS: reg_rdata <= receive_status_control;
                sync_serial_pkg::ADDR_DIVISOR_LOW: reg_rdata <= baud_divisor_low;
                sync_serial_pkg::ADDR_DIVISOR_HIGH: reg_rdata <= baud_divisor_high;
                sync_serial_pkg::ADDR_TRANSMIT_STATUS:
                    reg_rdata <= transmit_status_control | {6'h00, phase != TX, 1'b0};
                sync_serial_pkg::ADDR_RECEIVE_DATA: reg_rdata <= top[7:0];
                default: reg_rdata <= 8'h00;
            endcase
            if (!reg_read)
                reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // overrun keeps FIFO
    chk_overrun_keeps_fifo: assert property (@(posedge sys_clk) disable iff (reset)
        lost |=> overrun && fifo_count == 2'h2 - 2'($past(pop)))
        else $error("overrun lost FIFO state");
    chk_ready_tracks_fifo: assert property (@(posedge sys_clk) disable iff (reset)
        fifo_count != 2'h0 |=> receive_ready_flag || $past(pop))
        else $error("ready flag dropped with data");
    chk_single_clears: assert property (@(posedge sys_clk) disable iff (reset)
        (last_rx && single_rx) |=> !single_rx)
        else $error("single receive not cleared");
    chk_abort_idle: assert property (@(posedge sys_clk) disable iff (reset)
        abort |=> phase == IDLE)
        else $error("abort did not stop");
    chk_rx_driver_off: assert property (@(posedge sys_clk) disable iff (reset)
        rx_mode |=> !serial_data_pin_oe)
        else $error("data driver on in receive");
    chk_load_at_once: assert property (@(posedge sys_clk) disable iff (reset)
        load_tx |=> phase == TX && !holding_full)
        else $error("holding not loaded");
    chk_hold_waits: assert property (@(posedge sys_clk) disable iff (reset)
        (phase == TX && holding_full && !last_tx && port_on) |=> holding_full)
        else $error("holding lost while busy");
    chk_blocked_overrun: assert property (@(posedge sys_clk) disable iff (reset)
        (overrun && phase == IDLE) |=> phase != RX)
        else $error("receive started under overrun");
endmodule

/* rtl/sync_serial_pkg.sv */
// Purpose: constants for the synchronous serial transceiver
// Assumes: plain register port, byte-wide registers
// Notes: offsets are register indices on the plain port
package sync_serial_pkg;
    localparam logic [2:0] ADDR_BAUD_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RECEIVE_STATUS = 3'h1;
    localparam logic [2:0] ADDR_DIVISOR_LOW = 3'h2;
    localparam logic [2:0] ADDR_DIVISOR_HIGH = 3'h3;
    localparam logic [2:0] ADDR_TRANSMIT_DATA = 3'h4;
    localparam logic [2:0] ADDR_TRANSMIT_STATUS = 3'h5;
    localparam logic [2:0] ADDR_RECEIVE_DATA = 3'h6;
    // receive_status_control fields
    localparam int RS_PORT_ENABLE = 7;
    localparam int RS_NINTH_ENABLE = 6;
    localparam int RS_SINGLE = 5;
    localparam int RS_CONTINUOUS = 4;
    localparam int RS_OVERRUN = 1;
    localparam int RS_NINTH_BIT = 0;
    // transmit_status_control fields
    localparam int TS_MASTER = 7;
    localparam int TS_NINTH_ENABLE = 6;
    localparam int TS_ENABLE = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_SHIFTER_EMPTY = 1;
    localparam int TS_NINTH_BIT = 0;
    // baud_control_bits fields
    localparam int BC_RECEIVE_IDLE = 6;
    localparam int BC_POLARITY = 4;
    localparam int BC_WIDE = 3;
    // reset and read-back values, character lengths and FIFO depth
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_TRANSMIT_STATUS = 8'h02;
    localparam logic [3:0] BITS_NARROW = 4'h8;
    localparam logic [3:0] BITS_WIDE = 4'h9;
    localparam int FIFO_DEPTH = 2;
endpackage

/* dv/serial_peer.sv */
// Purpose: behavioural synchronous serial peer on the link pins
// Assumes: clock idles low, data changes on the rising clock edge
// Notes: makes the clock only when asked, else follows the wire
`timescale 1ns/100ps
module serial_peer (
    input wire logic clk_wire,
    input wire logic data_wire,
    input wire logic start,
    input wire logic gen,
    input wire logic [3:0] char_len,
    input wire logic [8:0] tx_word,
    output logic peer_clk,
    output logic peer_data,
    output logic [15:0] rx_word,
    output logic [4:0] rx_count
);
    int idx = 0;

    // idle state at time zero
    initial
    begin
        peer_clk = 1'b0;
        peer_data = 1'b0;
        rx_word = 16'h0000;
        rx_count = 5'h00;
    end

    always @(posedge start)
    begin
        idx = 0;
        rx_word = 16'h0000;
        rx_count = 5'h00;
        peer_data = ~tx_word[0];
        if (gen)
        begin
            repeat (char_len)
            begin
                #80 peer_clk = 1'b1;
                #80 peer_clk = 1'b0;
            end
        end
    end

    always @(posedge clk_wire)
    begin
        peer_data = tx_word[idx];
        idx = (idx + 1) % char_len;
    end

    always @(negedge clk_wire)
    begin
        if (rx_count < 5'h10)
        begin
            rx_word[rx_count] = data_wire;
            rx_count = rx_count + 5'h01;
        end
        #60 peer_data = ~peer_data; // stale bit scrambled once hold is over
    end
endmodule

/* dv/sync_serial_master_txrx_tb.sv */
// Purpose: self-checking bench for the synchronous serial transceiver
// Assumes: peer model on the link pins, register port driven by tasks
// Notes: divisor 3 gives a 160 ns link clock in master mode
`timescale 1ns/100ps
module sync_serial_master_txrx_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic dat_out, dat_oe, clk_out, clk_oe, rdy, tx_empty, peer_clk, peer_data;
    logic start = 1'b0;
    logic gen = 1'b0;
    logic [3:0] char_len = 4'h8;
    logic [8:0] tx_word = 9'h000;
    logic [15:0] rx_word;
    logic [4:0] rx_count;
    wire data_wire;
    wire clk_wire;
    int mismatches = 0;
    int samples_checked = 0;

    // -------------------------------------------------------------
    // link wires and instances
    // -------------------------------------------------------------
    assign data_wire = dat_oe ? dat_out : peer_data;
    assign clk_wire = clk_oe ? clk_out : peer_clk;

    always #10 sys_clk = ~sys_clk;

    sync_serial_master_txrx #(.DIVISOR_WIDTH(16)) u_sync_serial_master_txrx (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .serial_data_pin_in(data_wire), .serial_data_pin_out(dat_out),
        .serial_data_pin_oe(dat_oe), .serial_clock_pin_in(clk_wire),
        .serial_clock_pin_out(clk_out), .serial_clock_pin_oe(clk_oe),
        .receive_ready_flag(rdy), .transmit_empty_flag(tx_empty));

    serial_peer u_serial_peer (.clk_wire(clk_wire), .data_wire(data_wire), .start(start),
        .gen(gen), .char_len(char_len), .tx_word(tx_word), .peer_clk(peer_clk),
        .peer_data(peer_data), .rx_word(rx_word), .rx_count(rx_count));

    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'(exp));
    endtask

    task automatic peer_go(input logic g, input logic [3:0] len, input logic [8:0] w);
        @(posedge sys_clk);
        gen <= g;
        char_len <= len;
        tx_word <= w;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
    endtask

    task automatic wait_ready();
        int n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (rdy !== 1'b1 && n < 600);
        check(16'(rdy), 16'h0001);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic s_reset();
        rd(sync_serial_pkg::ADDR_TRANSMIT_STATUS, sync_serial_pkg::RESET_TRANSMIT_STATUS);
        rd(sync_serial_pkg::ADDR_TRANSMIT_DATA, 8'h00);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00);
        check(16'(clk_oe), 16'h0000);
        wr(sync_serial_pkg::ADDR_DIVISOR_LOW, 8'h03);
        wr(sync_serial_pkg::ADDR_DIVISOR_HIGH, 8'h00);
        rd(sync_serial_pkg::ADDR_DIVISOR_LOW, 8'h03);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        wr(sync_serial_pkg::ADDR_TRANSMIT_STATUS, 8'hB0);
    endtask

    task automatic s_tx();
        int k = 0;
        peer_go(1'b0, 4'h8, 9'h000);
        wr(sync_serial_pkg::ADDR_TRANSMIT_DATA, 8'hA5);
        wr(sync_serial_pkg::ADDR_TRANSMIT_DATA, 8'h3C);
        check(16'({dat_oe, clk_oe}), 16'h0003);
        while (rx_count !== 5'h10 && k < 800)
        begin
            @(posedge sys_clk);
            k++;
        end
        check(rx_word, 16'h3CA5);
        settle(30);
        check(16'(tx_empty), 16'h0001);
        rd(sync_serial_pkg::ADDR_TRANSMIT_STATUS, 8'hB2);
    endtask

    task automatic s_rx_single();
        wr(sync_serial_pkg::ADDR_TRANSMIT_STATUS, 8'h90);
        peer_go(1'b0, 4'h8, 9'h05A);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'hA0);
        wait_ready();
        check(16'(dat_oe), 16'h0000);
        settle(40);
        check(16'(rx_count), 16'h0008);
        rd(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        rd(sync_serial_pkg::ADDR_RECEIVE_DATA, 8'h5A);
        settle(2);
        check(16'(rdy), 16'h0000);
    endtask

    task automatic s_overrun();
        logic [4:0] snap;
        peer_go(1'b0, 4'h8, 9'h0C6);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'hB0);
        settle(500);
        rd(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h92);
        rd(sync_serial_pkg::ADDR_RECEIVE_DATA, 8'hC6);
        rd(sync_serial_pkg::ADDR_RECEIVE_DATA, 8'hC6);
        settle(300);
        check(16'(rdy), 16'h0000);
        rd(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h92);
        peer_go(1'b0, 4'h8, 9'h0C6);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        rd(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h90);
        settle(20);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        settle(2);
        snap = rx_count;
        check(16'(snap != 5'h00), 16'h0001);
        settle(50);
        check(16'(rx_count), 16'(snap));
        check(16'(rdy), 16'h0000);
        rd(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
    endtask

    task automatic s_nine();
        peer_go(1'b0, 4'h9, 9'h1C3);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'hE0);
        wait_ready();
        rd(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'hC1);
        rd(sync_serial_pkg::ADDR_RECEIVE_DATA, 8'hC3);
    endtask

    task automatic s_slave();
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        wr(sync_serial_pkg::ADDR_TRANSMIT_STATUS, 8'h10);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h90);
        settle(4);
        check(16'(clk_oe), 16'h0000);
        peer_go(1'b1, 4'h8, 9'h0E7);
        wait_ready();
        rd(sync_serial_pkg::ADDR_RECEIVE_DATA, 8'hE7);
        wr(sync_serial_pkg::ADDR_RECEIVE_STATUS, 8'h80);
        wr(sync_serial_pkg::ADDR_TRANSMIT_STATUS, 8'h90);
        wr(sync_serial_pkg::ADDR_BAUD_CONTROL, 8'h10);
        settle(6);
        check(16'({clk_oe, clk_out}), 16'h0003);
    endtask

    // -------------------------------------------------------------
    // verdict, main sequence and watchdog
    // -------------------------------------------------------------
    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        s_reset();
        s_tx();
        s_rx_single();
        s_overrun();
        s_nine();
        s_slave();
        test_done();
    end

    // cuts a hang well past the expected run
    initial
    begin
        #200000;
        mismatches++;
        test_done();
    end
endmodule
